/* File: src/apc_pkg.sv */
// Purpose: Constants for the converter configuration register bank
// Assumes: 13-bit register addresses on the three-wire control port
// Notes:   Open bits read back as zero
package apc_pkg;
	localparam int          ADDR_W           = 13;
	localparam int          INSTR_BITS       = 16;
	localparam int          BYTE_BITS        = 8;

	localparam logic [12:0] ADDR_CHANNEL_SEL = 13'h0005;
	localparam logic [12:0] ADDR_POWER_MODE  = 13'h0008;
	localparam logic [12:0] ADDR_ENHANCE     = 13'h000C;
	localparam logic [12:0] ADDR_OUT_MODE    = 13'h0014;
	localparam logic [12:0] ADDR_OUT_ADJUST  = 13'h0015;
	localparam logic [12:0] ADDR_CLK_PHASE   = 13'h0016;
	localparam logic [12:0] ADDR_SERIAL_OUT  = 13'h0021;
	localparam logic [12:0] ADDR_TRANSFER    = 13'h00FF;
	localparam logic [12:0] ADDR_RES_RATE    = 13'h0100;
	localparam logic [12:0] ADDR_USER_IO2    = 13'h0101;

	localparam logic [7:0]  RST_CHANNEL_SEL  = 8'h3F;
	localparam logic [7:0]  RST_POWER_MODE   = 8'h00;
	localparam logic [7:0]  RST_ENHANCE      = 8'h00;
	localparam logic [7:0]  RST_OUT_MODE     = 8'h01;
	localparam logic [7:0]  RST_OUT_ADJUST   = 8'h00;
	localparam logic [7:0]  RST_CLK_PHASE    = 8'h03;
	localparam logic [7:0]  RST_SERIAL_OUT   = 8'h32;
	localparam logic [7:0]  RST_RES_RATE     = 8'h00;
	localparam logic [7:0]  RST_USER_IO2     = 8'h00;

	// Writable-bit masks: everything else is open
	localparam logic [7:0]  MASK_CHANNEL_SEL = 8'h3F;
	localparam logic [7:0]  MASK_POWER_MODE  = 8'h23;
	localparam logic [7:0]  MASK_ENHANCE     = 8'h04;
	localparam logic [7:0]  MASK_OUT_MODE    = 8'h45;
	localparam logic [7:0]  MASK_OUT_ADJUST  = 8'h31;
	localparam logic [7:0]  MASK_CLK_PHASE   = 8'h7F;
	localparam logic [7:0]  MASK_SERIAL_OUT  = 8'hF7;
	localparam logic [7:0]  MASK_RES_RATE    = 8'h77;
	localparam logic [7:0]  MASK_USER_IO2    = 8'h01;

	localparam int          POS_PIN_FUNC     = 5;
	localparam int          POS_CHOP         = 2;
	localparam int          POS_REDUCED      = 6;
	localparam int          POS_INVERT       = 2;
	localparam int          POS_TWOS         = 0;
	localparam int          POS_TERM_LO      = 4;
	localparam int          POS_DRIVE        = 0;
	localparam int          POS_IN_PHASE_LO  = 4;
	localparam int          POS_TRANSFER     = 0;
	localparam int          POS_PULLDN_DIS   = 0;
	localparam int          POS_SEL_FRAME    = 4;
	localparam int          POS_SEL_DATACLK  = 5;

	localparam int          RESET_RECOVERY_CYCLES = 2900000;

	typedef enum logic [1:0] {
		PM_NORMAL  = 2'b00,
		PM_PWRDOWN = 2'b01,
		PM_STANDBY = 2'b10,
		PM_DIGRST  = 2'b11
	} apc_mode_e;

	typedef enum logic {
		PH_INSTR,
		PH_DATA
	} apc_phase_e;
endpackage : apc_pkg

/* File: src/apc_config_bank.sv */
// Purpose: Configuration register bank behind the three-wire control port
// Assumes: sclk, csN and sdioIn are synchronous to clk; sampleTick marks sample clock
// Notes:   Only rst resets the control port and registers
module apc_config_bank #(
	parameter int RecoveryCycles = apc_pkg::RESET_RECOVERY_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       csN,
	input  wire logic       sdioIn,
	output logic            sdioOut,
	output logic            sdioOe,
	input  wire logic       powerDownPin,
	input  wire logic       sampleTick,
	output logic            datapathClkEn,
	output logic            datapathRst,
	output logic            outputsEn,
	output logic            outputsZero,
	output logic            chopEn,
	output logic            reducedSwing,
	output logic            outputInvert,
	output logic            twosComplement,
	output logic [1:0]      termSel,
	output logic            frameClockOutDouble,
	output logic            dataClockOutDouble,
	output logic [2:0]      inputClkPhase,
	output logic [3:0]      outputClkPhase,
	output logic [7:0]      serialOutCtrl,
	output logic [7:0]      rateOverrideActive,
	output logic [3:0]      channelSel,
	output logic            sdioPullDownDis
);

	logic [7:0]              chanSel_q;
	logic [7:0]              powerMode_q;
	logic [7:0]              enhance_q;
	logic [7:0]              outMode_q;
	logic [7:0]              outAdjust_q;
	logic [7:0]              clkPhase_q;
	logic [7:0]              serialOut_q;
	logic [7:0]              resRatePend_q;
	logic [7:0]              resRateAct_q;
	logic [7:0]              userIo2_q;
	logic                    frameDrive_q;
	logic                    dataClkDrive_q;

	logic                    sclkPrev_q;
	apc_pkg::apc_phase_e     phase_q;
	logic [4:0]              bitCnt_q;
	logic [15:0]             instr_q;
	logic [7:0]              wrShift_q;
	logic                    readOp_q;
	logic [12:0]             addr_q;
	logic [7:0]              rdShift_q;
	logic                    reloadPend_q;
	logic                    shiftPend_q;
	logic                    sdioOe_q;

	logic                    sclkRise;
	logic                    sclkFall;
	logic                    wrStrobe;
	logic [12:0]             wrAddr;
	logic [7:0]              wrData;
	logic [15:0]             instrNext;

	apc_pkg::apc_mode_e      effMode;
	logic                    modeDigRst;
	// Counter sized from the parameter so a long recovery is never cut short
	localparam int           RecoverW = $clog2(RecoveryCycles + 1);
	logic [RecoverW-1:0]     recoverCnt_q;

	// Read decode, shared by the first byte and every following byte
	function automatic logic [7:0] readReg(input logic [12:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			apc_pkg::ADDR_CHANNEL_SEL: v = chanSel_q;
			apc_pkg::ADDR_POWER_MODE:  v = powerMode_q;
			apc_pkg::ADDR_ENHANCE:     v = enhance_q;
			apc_pkg::ADDR_OUT_MODE:    v = outMode_q;
			apc_pkg::ADDR_OUT_ADJUST:  v = {outAdjust_q[7:1], frameDrive_q | dataClkDrive_q};
			apc_pkg::ADDR_CLK_PHASE:   v = clkPhase_q;
			apc_pkg::ADDR_SERIAL_OUT:  v = serialOut_q;
			apc_pkg::ADDR_RES_RATE:    v = resRatePend_q;
			apc_pkg::ADDR_USER_IO2:    v = userIo2_q;
			default:                   v = 8'h00;
		endcase
		return v;
	endfunction : readReg

	// Write strobe aimed at one address, shared by the split write processes
	function automatic logic wrHit(input logic [12:0] a);
		return wrStrobe && (wrAddr == a);
	endfunction : wrHit

	assign sclkRise  = !csN && sclk && !sclkPrev_q;
	assign sclkFall  = !csN && !sclk && sclkPrev_q;
	assign instrNext = {instr_q[14:0], sdioIn};

	// Port state depends on rst only, never on any power mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclkPrev_q <= 1'b0;
		end else begin
			sclkPrev_q <= sclk;
		end
	end

	// Instruction and data framing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q   <= apc_pkg::PH_INSTR;
			bitCnt_q  <= 5'd0;
			instr_q   <= 16'h0000;
			wrShift_q <= 8'h00;
			readOp_q  <= 1'b0;
			addr_q    <= 13'h0000;
		end else if (csN) begin
			phase_q  <= apc_pkg::PH_INSTR;
			bitCnt_q <= 5'd0;
		end else if (sclkRise) begin
			unique case (phase_q)
				apc_pkg::PH_INSTR: begin
					instr_q <= instrNext;
					if (bitCnt_q == 5'(apc_pkg::INSTR_BITS - 1)) begin
						phase_q  <= apc_pkg::PH_DATA;
						bitCnt_q <= 5'd0;
						readOp_q <= instrNext[15];
						addr_q   <= instrNext[12:0];
					end else begin
						bitCnt_q <= bitCnt_q + 5'd1;
					end
				end
				apc_pkg::PH_DATA: begin
					wrShift_q <= {wrShift_q[6:0], sdioIn};
					if (bitCnt_q == 5'(apc_pkg::BYTE_BITS - 1)) begin
						bitCnt_q <= 5'd0;
						addr_q   <= addr_q - 13'd1;
					end else begin
						bitCnt_q <= bitCnt_q + 5'd1;
					end
				end
			endcase
		end
	end

	assign wrStrobe = sclkRise && !readOp_q && (phase_q == apc_pkg::PH_DATA)
		&& (bitCnt_q == 5'(apc_pkg::BYTE_BITS - 1));
	assign wrAddr   = addr_q;
	assign wrData   = {wrShift_q[6:0], sdioIn};

	// Read data: present MSB first; first byte loads on the last instruction rising edge, later changes on falling edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdShift_q    <= 8'h00;
			reloadPend_q <= 1'b0;
			shiftPend_q  <= 1'b0;
			sdioOe_q     <= 1'b0;
		end else if (csN) begin
			sdioOe_q     <= 1'b0;
			reloadPend_q <= 1'b0;
			shiftPend_q  <= 1'b0;
		end else if (sclkRise) begin
			if (phase_q == apc_pkg::PH_INSTR
				&& bitCnt_q == 5'(apc_pkg::INSTR_BITS - 1)) begin
				rdShift_q <= readReg(instrNext[12:0]);
				sdioOe_q  <= instrNext[15];
			end else if (phase_q == apc_pkg::PH_DATA) begin
				reloadPend_q <= (bitCnt_q == 5'(apc_pkg::BYTE_BITS - 1));
				shiftPend_q  <= (bitCnt_q != 5'(apc_pkg::BYTE_BITS - 1));
			end
		end else if (sclkFall) begin
			if (reloadPend_q) begin
				rdShift_q <= readReg(addr_q);
			end else if (shiftPend_q) begin
				rdShift_q <= {rdShift_q[6:0], 1'b0};
			end
			reloadPend_q <= 1'b0;
			shiftPend_q  <= 1'b0;
		end
	end

	assign sdioOut = rdShift_q[7];
	assign sdioOe  = sdioOe_q;

	// Configuration registers take effect on the write itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chanSel_q      <= apc_pkg::RST_CHANNEL_SEL;
			powerMode_q    <= apc_pkg::RST_POWER_MODE;
			enhance_q      <= apc_pkg::RST_ENHANCE;
			outMode_q      <= apc_pkg::RST_OUT_MODE;
			outAdjust_q    <= apc_pkg::RST_OUT_ADJUST;
			clkPhase_q     <= apc_pkg::RST_CLK_PHASE;
			serialOut_q    <= apc_pkg::RST_SERIAL_OUT;
			userIo2_q      <= apc_pkg::RST_USER_IO2;
		end else if (wrStrobe) begin
			unique case (wrAddr)
				apc_pkg::ADDR_CHANNEL_SEL:
					chanSel_q <= wrData & apc_pkg::MASK_CHANNEL_SEL;
				apc_pkg::ADDR_POWER_MODE:
					powerMode_q <= wrData & apc_pkg::MASK_POWER_MODE;
				apc_pkg::ADDR_ENHANCE:
					enhance_q <= wrData & apc_pkg::MASK_ENHANCE;
				apc_pkg::ADDR_OUT_MODE:
					outMode_q <= wrData & apc_pkg::MASK_OUT_MODE;
				apc_pkg::ADDR_OUT_ADJUST:
					outAdjust_q <= wrData & apc_pkg::MASK_OUT_ADJUST;
				apc_pkg::ADDR_CLK_PHASE:
					clkPhase_q <= wrData & apc_pkg::MASK_CLK_PHASE;
				apc_pkg::ADDR_SERIAL_OUT:
					serialOut_q <= wrData & apc_pkg::MASK_SERIAL_OUT;
				apc_pkg::ADDR_USER_IO2:
					userIo2_q <= wrData & apc_pkg::MASK_USER_IO2;
				default: begin
				end
			endcase
		end
	end

	// Drive applies only to clock outputs picked in channel select at write time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameDrive_q   <= 1'b0;
			dataClkDrive_q <= 1'b0;
		end else if (wrHit(apc_pkg::ADDR_OUT_ADJUST)) begin
			if (chanSel_q[apc_pkg::POS_SEL_FRAME]) begin
				frameDrive_q <= wrData[apc_pkg::POS_DRIVE];
			end
			if (chanSel_q[apc_pkg::POS_SEL_DATACLK]) begin
				dataClkDrive_q <= wrData[apc_pkg::POS_DRIVE];
			end
		end
	end

	// Override is only staged here; it reaches use through the transfer bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resRatePend_q <= apc_pkg::RST_RES_RATE;
		end else if (wrHit(apc_pkg::ADDR_RES_RATE)) begin
			resRatePend_q <= wrData & apc_pkg::MASK_RES_RATE;
		end
	end

	// Transfer bit is self-clearing; it copies the pending override into use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resRateAct_q <= apc_pkg::RST_RES_RATE;
		end else if (wrHit(apc_pkg::ADDR_TRANSFER)
			&& wrData[apc_pkg::POS_TRANSFER]) begin
			resRateAct_q <= resRatePend_q;
		end
	end

	// Pin overrides the field: power-down or standby per bit 5
	always_comb begin
		if (powerDownPin) begin
			effMode = powerMode_q[apc_pkg::POS_PIN_FUNC] ? apc_pkg::PM_PWRDOWN
				: apc_pkg::PM_STANDBY;
		end else begin
			effMode = apc_pkg::apc_mode_e'(powerMode_q[1:0]);
		end
	end

	assign modeDigRst = (effMode == apc_pkg::PM_DIGRST);

	// Recovery counts sample clock ticks after digital reset releases
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			recoverCnt_q <= '0;
		end else if (modeDigRst) begin
			recoverCnt_q <= RecoverW'(RecoveryCycles);
		end else if (sampleTick && recoverCnt_q != '0) begin
			recoverCnt_q <= recoverCnt_q - RecoverW'(1);
		end
	end

	// Power state decode; only normal mode runs clocks and outputs
	always_comb begin
		datapathClkEn = 1'b0;
		datapathRst   = 1'b0;
		outputsEn     = 1'b0;
		unique case (effMode)
			apc_pkg::PM_NORMAL: begin
				datapathClkEn = 1'b1;
				outputsEn     = 1'b1;
			end
			apc_pkg::PM_PWRDOWN: begin
				datapathRst = 1'b1;
			end
			apc_pkg::PM_STANDBY: begin
				datapathRst = 1'b0;
			end
			apc_pkg::PM_DIGRST: begin
				datapathRst = 1'b1;
			end
		endcase
	end

	assign outputsZero = modeDigRst || (recoverCnt_q != '0);

	assign chopEn         = enhance_q[apc_pkg::POS_CHOP];
	assign reducedSwing   = outMode_q[apc_pkg::POS_REDUCED];
	assign outputInvert   = outMode_q[apc_pkg::POS_INVERT];
	assign twosComplement = outMode_q[apc_pkg::POS_TWOS];
	assign termSel        = outAdjust_q[apc_pkg::POS_TERM_LO +: 2];

	// Any termination choice masks double drive
	assign frameClockOutDouble = frameDrive_q && (termSel == 2'b00);
	assign dataClockOutDouble  = dataClkDrive_q && (termSel == 2'b00);

	assign inputClkPhase  = clkPhase_q[apc_pkg::POS_IN_PHASE_LO +: 3];
	assign outputClkPhase = clkPhase_q[3:0];
	assign serialOutCtrl  = serialOut_q;
	// Limits capability only; no effect on sample timing here
	assign rateOverrideActive = resRateAct_q;
	assign channelSel         = chanSel_q[3:0];
	assign sdioPullDownDis    = userIo2_q[apc_pkg::POS_PULLDN_DIS];

endmodule : apc_config_bank

/* File: tb/apc_config_bank_assertions.sv */
// Purpose: Port-level checks of the configuration register bank
// Assumes: Ports of apc_config_bank, one clock domain
// Notes:   Bound from the bench top file
module apc_config_bank_assertions #(
	parameter int RecoveryCycles = 5
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       csN,
	input wire logic       powerDownPin,
	input wire logic       sampleTick,
	input wire logic       sdioOe,
	input wire logic       datapathClkEn,
	input wire logic       datapathRst,
	input wire logic       outputsEn,
	input wire logic       outputsZero,
	input wire logic       chopEn,
	input wire logic       twosComplement,
	input wire logic [1:0] termSel,
	input wire logic       frameClockOutDouble,
	input wire logic       dataClockOutDouble,
	input wire logic [7:0] rateOverrideActive
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_RST_STOPS: assert property (datapathRst |-> !datapathClkEn && !outputsEn)
		else $error("datapath reset with clocks or outputs running");
	AST_CLK_OUT_EQ: assert property (datapathClkEn == outputsEn)
		else $error("datapath clock and output enables disagree");
	AST_NORMAL: assert property (datapathClkEn |-> !datapathRst)
		else $error("running datapath held in reset");
	AST_PIN_STOPS: assert property (powerDownPin |-> !datapathClkEn && !outputsEn)
		else $error("power-down pin did not stop the datapath");
	AST_TERM_WINS: assert property (frameClockOutDouble || dataClockOutDouble |-> termSel == 2'b00)
		else $error("double drive active with a termination selected");
	AST_OE_RELEASE: assert property (csN && $past(csN) |-> !sdioOe)
		else $error("data pin driven while deselected");
	AST_IDLE_STABLE: assert property (csN && $past(csN) |-> $stable({chopEn, twosComplement, termSel}))
		else $error("settings changed without a write");
	AST_OVR_WRITE: assert property ($changed(rateOverrideActive) |-> !$past(csN))
		else $error("active override changed outside a write");
	AST_ZERO_FALL: assert property ($fell(outputsZero) |-> $past(sampleTick))
		else $error("zero outputs ended without a sample tick");
	AST_ZERO_HOLD: assert property (outputsZero && !sampleTick |=> outputsZero)
		else $error("zero outputs ended early");
	COV_RECOVER: cover property ($fell(outputsZero));
	COV_READ: cover property ($rose(sdioOe));
	COV_DOUBLE: cover property ($rose(frameClockOutDouble));
endmodule : apc_config_bank_assertions

/* File: tb/apc_host_model.sv */
// Purpose: Host side of the three-wire control port
// Assumes: sclk idles low, two clk cycles per sclk phase
// Notes:   Reads are sampled while sclk is high
module apc_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      csN,
	output logic      sdioIn,
	input  wire logic sdioOut,
	input  wire logic sdioOe,
	input  wire logic pullDownDis
);
	timeunit 1ns;
	timeprecision 100ps;
	logic hostOe;
	logic hostBit;
	// Released wire floats to a changing level once the pull-down is off
	assign sdioIn = sdioOe ? sdioOut : hostOe ? hostBit : pullDownDis ? ~hostBit : 1'b0;
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		hostOe = 1'b0;
		hostBit = 1'b0;
	end
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [23:0] sh;
		sh = {rd, 2'b00, a, wd};
		q = 8'h00;
		csN = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sclk = 1'b0;
			hostOe = !(rd && i < 8);
			hostBit = sh[i];
			repeat (2) @(posedge clk);
			#1 sclk = 1'b1;
			repeat (2) @(posedge clk);
			#1 if (rd && i < 8) q[i] = sdioIn;
		end
		sclk = 1'b0;
		repeat (2) @(posedge clk);
		#1 csN = 1'b1;
		hostOe = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : xfer
endmodule : apc_host_model

/* File: tb/adc_power_output_config_bank_test.sv */
// Purpose: Self-checking bench of the configuration register bank
// Assumes: Short recovery count, host model on the control port
// Notes:   Register model kept in tables below
module adc_power_output_config_bank_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RecCycles = 5;
	logic clk, rst, sclk, csN, sdioIn, sdioOut, sdioOe, powerDownPin, sampleTick;
	logic datapathClkEn, datapathRst, outputsEn, outputsZero, chopEn, reducedSwing;
	logic outputInvert, twosComplement, frameClockOutDouble, dataClockOutDouble;
	logic sdioPullDownDis;
	logic [1:0]  termSel;
	logic [2:0]  inputClkPhase;
	logic [3:0]  outputClkPhase, channelSel;
	logic [7:0]  serialOutCtrl, rateOverrideActive, q, act;
	logic [31:0] seed = 32'h39;
	int          fails, checkCount, n, e;
	logic [12:0] adr [10] = '{13'h005, 13'h008, 13'h00C, 13'h014, 13'h015, 13'h016,
		13'h021, 13'h0FF, 13'h100, 13'h101};
	logic [7:0]  rv  [10] = '{8'h3F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h32, 8'h00, 8'h00, 8'h00};
	logic [7:0]  msk [10] = '{8'h3F, 8'h23, 8'h04, 8'h45, 8'h31, 8'h7F, 8'hF7, 8'h00, 8'h77, 8'h01};
	logic [7:0]  mdl [10];
	apc_config_bank #(.RecoveryCycles(RecCycles)) dut (.clk(clk), .rst(rst), .sclk(sclk),
		.csN(csN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
		.powerDownPin(powerDownPin), .sampleTick(sampleTick), .datapathClkEn(datapathClkEn),
		.datapathRst(datapathRst), .outputsEn(outputsEn), .outputsZero(outputsZero),
		.chopEn(chopEn), .reducedSwing(reducedSwing), .outputInvert(outputInvert),
		.twosComplement(twosComplement), .termSel(termSel),
		.frameClockOutDouble(frameClockOutDouble), .dataClockOutDouble(dataClockOutDouble),
		.inputClkPhase(inputClkPhase), .outputClkPhase(outputClkPhase),
		.serialOutCtrl(serialOutCtrl), .rateOverrideActive(rateOverrideActive),
		.channelSel(channelSel), .sdioPullDownDis(sdioPullDownDis));
	apc_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
		.sdioOut(sdioOut), .sdioOe(sdioOe), .pullDownDis(sdioPullDownDis));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic finishTest();
		if (fails == 0 && checkCount > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finishTest
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wi(input int i, input logic [7:0] d);
		host.xfer(1'b0, adr[i], d, q);
		mdl[i] = d & msk[i];
	endtask : wi
	task automatic rdchk(input int i);
		host.xfer(1'b1, adr[i], 8'h00, q);
		chk(q, mdl[i]);
	endtask : rdchk
	task automatic outs();
		chk({chopEn, reducedSwing, outputInvert, twosComplement, termSel, 2'b00},
			{mdl[2][2], mdl[3][6], mdl[3][2], mdl[3][0], mdl[4][5:4], 2'b00});
		chk({1'b0, inputClkPhase, outputClkPhase}, {1'b0, mdl[5][6:0]});
		chk(serialOutCtrl, mdl[6]);
		chk(rateOverrideActive, act);
		chk({3'b000, sdioPullDownDis, channelSel}, {3'b000, mdl[9][0], mdl[0][3:0]});
	endtask : outs
	initial begin
		repeat (100000) @(posedge clk);
		$display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h000186A0, 32'h00000000);
		fails++;
		finishTest();
	end
	initial begin
		rst = 1'b1;
		powerDownPin = 1'b0;
		sampleTick = 1'b0;
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		repeat (2) @(posedge clk);
		#1 mdl = rv;
		act = 8'h00;
		for (int i = 0; i < 10; i++) rdchk(i);
		outs();
		host.xfer(1'b0, 13'h003, 8'hFF, q);
		host.xfer(1'b1, 13'h003, 8'h00, q);
		chk(q, 8'h00);
		// Phase field random; channel select keeps both clock output picks set
		for (int i = 0; i < 10; i++) if (i != 7) wi(i, i == 0 ? 8'(rnd()) | 8'h30 : 8'(rnd()));
		for (int i = 0; i < 10; i++) rdchk(i);
		outs();
		wi(7, 8'hFE);
		outs();
		wi(7, 8'h01);
		act = mdl[8];
		outs();
		rdchk(7);
		for (int m = 0; m < 16; m++) begin
			wi(1, {2'b00, m[2], 3'b000, m[1:0]});
			powerDownPin = m[3];
			@(posedge clk);
			#1 e = m[3] ? (m[2] ? 1 : 2) : m[1:0];
			chk({5'b0, datapathClkEn, outputsEn, datapathRst},
				e == 0 ? 8'h06 : e == 2 ? 8'h00 : 8'h01);
		end
		powerDownPin = 1'b0;
		wi(1, 8'h03);
		rdchk(1);
		chk({7'b0, outputsZero}, 8'h01);
		wi(1, 8'h00);
		n = 0;
		for (int k = 0; k < 300 && outputsZero !== 1'b0; k++) begin
			sampleTick = 1'(rnd());
			n += sampleTick;
			@(posedge clk);
			#1;
		end
		sampleTick = 1'b0;
		if (outputsZero !== 1'b0) begin
			chk({7'b0, outputsZero}, 8'h00);
			finishTest();
		end
		chk(8'(n), 8'(RecCycles));
		wi(4, 8'h00);
		wi(0, 8'h10);
		wi(4, 8'h01);
		chk({6'b0, frameClockOutDouble, dataClockOutDouble}, 8'h02);
		wi(0, 8'h3F);
		wi(4, 8'h11);
		chk({6'b0, frameClockOutDouble, dataClockOutDouble}, 8'h00);
		wi(4, 8'h01);
		chk({6'b0, frameClockOutDouble, dataClockOutDouble}, 8'h03);
		rdchk(4);
		finishTest();
	end
endmodule : adc_power_output_config_bank_test
bind apc_config_bank apc_config_bank_assertions #(.RecoveryCycles(RecoveryCycles)) u_chk (
	.clk(clk), .rst(rst), .csN(csN), .powerDownPin(powerDownPin), .sampleTick(sampleTick),
	.sdioOe(sdioOe), .datapathClkEn(datapathClkEn), .datapathRst(datapathRst),
	.outputsEn(outputsEn), .outputsZero(outputsZero), .chopEn(chopEn),
	.twosComplement(twosComplement), .termSel(termSel),
	.frameClockOutDouble(frameClockOutDouble), .dataClockOutDouble(dataClockOutDouble),
	.rateOverrideActive(rateOverrideActive));
